// ---- verilog/sfp_host.sv ----
// host controller that programs and reads a parallel sector flash for avalon software
`timescale 1ns/10ps
module sfp_host
  import sfp_pkg::*;
#(
  parameter int PWR_WAIT = sfp_pkg::PWR_CYC,
  parameter int POLL_MAX = sfp_pkg::PROG_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [sfp_pkg::BUS_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [sfp_pkg::FL_AW-1:0] addr_bus,
  output logic [sfp_pkg::FL_DW-1:0] data_bus_o,
  output logic data_bus_oe,
  input wire logic [sfp_pkg::FL_DW-1:0] data_bus_i,
  output logic ce_n,
  output logic oe_n,
  output logic we_n
);
  import sfp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] rst_sync_ff;
  logic rst_n;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) rst_sync_ff <= 2'h0;
    else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle on every access
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [2:0] op_ff;
  logic [FL_AW-1:0] addr_ff;
  logic done_ff;
  logic tmo_ff;
  logic [FL_DW-1:0] rdat_ff;
  sfp_state_t st_ff;
  wire req = avs_read | avs_write;
  wire fire_wr = avs_write & ack_ff;
  wire hit_ctrl = avs_address == REG_CTRL;
  wire hit_addr = avs_address == REG_ADDR;
  wire hit_stat = avs_address == REG_STAT;
  wire hit_rdat = avs_address == REG_RDAT;
  wire hit_buf = avs_address[BUF_SEL_BIT];
  wire idle = st_ff == S_IDLE;
  wire [31:0] lane_m = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}},
                        {8{avs_byteenable[0]}}};
  wire [31:0] stat_w = {28'h0, st_ff != S_PWR, tmo_ff, done_ff, !idle};
  wire [2:0] new_op = avs_writedata[2:0];
  wire op_ok = new_op >= OP_READ && new_op <= OP_ID_EXIT;
  // commands while busy are dropped; the busy bit tells software to wait
  wire start = fire_wr & hit_ctrl & avs_byteenable[0] & idle & op_ok;
  wire [31:0] addr_m = ({13'h0, addr_ff} & ~lane_m) | (avs_writedata & lane_m);
  wire [31:0] rd_mux = hit_ctrl ? {29'h0, op_ff} :
                       hit_addr ? {13'h0, addr_ff} :
                       hit_stat ? stat_w :
                       hit_rdat ? {24'h0, rdat_ff} : 32'h0;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0;
    end else begin
      ack_ff <= req & ~ack_ff;
      if (req & ~ack_ff) rdata_ff <= rd_mux;
    end
  end
  assign avs_waitrequest = req & ~ack_ff;
  assign avs_readdata = rdata_ff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) addr_ff <= '0;
    else if (fire_wr & hit_addr & idle) addr_ff <= addr_m[FL_AW-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // sector buffer: software fills it while the engine is idle
  logic load_ff;
  logic [8:0] byte_ff;
  sfp_buf_if #(.DW(FL_DW), .AW(BUF_AW)) buf_if ();
  assign buf_if.we = fire_wr & hit_buf & avs_byteenable[0] & idle;
  assign buf_if.waddr = avs_address[BUF_AW+1:2];
  assign buf_if.wdata = avs_writedata[FL_DW-1:0];
  assign buf_if.raddr = byte_ff[BUF_AW-1:0];
  sfp_sect_buf #(.DW(FL_DW), .AW(BUF_AW)) u_buf (
    .clock(clock),
    .bus(buf_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // access engine
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] tmo_cnt_ff;
  logic [4:0] seq_ff;
  logic [4:0] seq_end_ff;
  logic fin_ff;
  logic poll_ff;
  logic prev_ok_ff;
  logic prev6_ff;
  logic prev_fin_ff;
  wire cnt_zero = cnt_ff == '0;
  wire [26:0] tbl = SEQ_TBL[seq_ff];
  wire [FL_AW-1:0] wr_addr = load_ff ? {addr_ff[FL_AW-1:8], byte_ff[7:0]} :
                             fin_ff ? addr_ff : tbl[26:8];
  wire [FL_DW-1:0] wr_data = load_ff ? buf_if.rdata : fin_ff ? LOCK_DATA : tbl[7:0];
  wire [FL_AW-1:0] rd_addr = (poll_ff && op_ff == OP_PROG) ? {addr_ff[FL_AW-1:8], 8'hff} : addr_ff;
  wire seq_more = !load_ff && !fin_ff && (seq_ff + 5'h1 != seq_end_ff);
  wire byte_more = load_ff && byte_ff != 9'h0ff;
  // for program both polling methods must agree before the cycle counts as finished; erase and lock use the toggle bit alone
  wire poll_hit = prev_ok_ff && data_bus_i[6] == prev6_ff
                  && (op_ff != OP_PROG || data_bus_i[7] == buf_if.rdata[7]);
  wire [4:0] op_seq = op_ff == OP_LOCK ? SEQ_LOCK : op_ff == OP_ERASE ? SEQ_ERASE :
                      op_ff == OP_ID_ENTER ? SEQ_IDIN : op_ff == OP_ID_EXIT ? SEQ_IDOUT : SEQ_UNLK;
  wire [4:0] new_seq = new_op == OP_LOCK ? SEQ_LOCK : new_op == OP_ERASE ? SEQ_ERASE :
                       new_op == OP_ID_ENTER ? SEQ_IDIN : new_op == OP_ID_EXIT ? SEQ_IDOUT : SEQ_UNLK;
  wire [4:0] new_end = new_op == OP_LOCK ? SEQ_ERASE : new_op == OP_ERASE ? SEQ_IDIN :
                       new_op == OP_ID_ENTER ? SEQ_IDOUT : new_op == OP_ID_EXIT ? SEQ_END : SEQ_LOCK;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= S_PWR;
      cnt_ff <= '0;
      op_ff <= 3'h0;
      seq_ff <= 5'h0;
      seq_end_ff <= 5'h0;
      load_ff <= 1'b0;
      fin_ff <= 1'b0;
      poll_ff <= 1'b0;
      byte_ff <= 9'h0;
    end else begin
      if (!cnt_zero) cnt_ff <= cnt_ff - 1'b1;
      case (st_ff)
        S_PWR: begin
          if (cnt_ff == CNT_W'(PWR_WAIT - 1)) st_ff <= S_IDLE;
          else cnt_ff <= cnt_ff + 1'b1;
        end
        S_IDLE: begin
          if (start) begin
            op_ff <= new_op;
            seq_ff <= new_seq;
            seq_end_ff <= new_end;
            load_ff <= 1'b0;
            fin_ff <= 1'b0;
            poll_ff <= 1'b0;
            byte_ff <= 9'h0;
            st_ff <= new_op == OP_READ ? S_RLOW : S_WSET;
            cnt_ff <= new_op == OP_READ ? CNT_W'(ACC_CYC) : CNT_W'(SETUP_CYC - 1);
          end
        end
        S_WSET: if (cnt_zero) begin
          st_ff <= S_WLOW;
          cnt_ff <= CNT_W'(WP_CYC - 1);
        end
        S_WLOW: if (cnt_zero) begin
          st_ff <= S_WREC;
          cnt_ff <= CNT_W'(REC_CYC - 1);
        end
        S_WREC: if (cnt_zero) begin
          // every path back to a load is a few dozen cycles, far inside the gap limit
          st_ff <= S_WSET;
          cnt_ff <= CNT_W'(SETUP_CYC - 1);
          if (seq_more) seq_ff <= seq_ff + 5'h1;
          else if (op_ff == OP_PROG && !load_ff) load_ff <= 1'b1;
          else if (byte_more) byte_ff <= byte_ff + 9'h1;
          else if (op_ff == OP_LOCK && !fin_ff) fin_ff <= 1'b1;
          else if (op_ff == OP_PROG || op_ff == OP_LOCK || op_ff == OP_ERASE) begin
            load_ff <= 1'b0;
            poll_ff <= 1'b1;
            st_ff <= S_RLOW;
            cnt_ff <= CNT_W'(ACC_CYC);
          end else begin
            st_ff <= S_IDLE;
          end
        end
        S_RLOW: if (cnt_zero) begin
          st_ff <= S_RREC;
          cnt_ff <= CNT_W'(REC_CYC - 1);
        end
        S_RREC: if (cnt_zero) begin
          if (poll_ff && !prev_fin_ff) begin
            st_ff <= S_RLOW;
            cnt_ff <= CNT_W'(ACC_CYC);
          end else begin
            st_ff <= S_IDLE;
          end
        end
        default: st_ff <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read capture and completion polling
  wire sample = st_ff == S_RLOW && cnt_zero;
  wire nxt_idle = (st_ff == S_RREC && cnt_zero && (!poll_ff || prev_fin_ff)) ||
                  (st_ff == S_WREC && cnt_zero && !seq_more && !byte_more &&
                   !(op_ff == OP_PROG && !load_ff) && !(op_ff == OP_LOCK && !fin_ff) &&
                   !(op_ff == OP_PROG || op_ff == OP_LOCK || op_ff == OP_ERASE));
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdat_ff <= 8'h0;
      prev_ok_ff <= 1'b0;
      prev6_ff <= 1'b0;
      prev_fin_ff <= 1'b0;
      tmo_cnt_ff <= '0;
      tmo_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      if (start) begin
        prev_ok_ff <= 1'b0;
        prev_fin_ff <= 1'b0;
        tmo_cnt_ff <= CNT_W'(POLL_MAX);
        tmo_ff <= 1'b0;
        done_ff <= 1'b0;
      end else if (poll_ff && !cnt_zero && tmo_cnt_ff != '0) begin
        tmo_cnt_ff <= tmo_cnt_ff - 1'b1;
      end
      if (sample) begin
        rdat_ff <= data_bus_i;
        prev6_ff <= data_bus_i[6];
        prev_ok_ff <= 1'b1;
        if (poll_ff && poll_hit) prev_fin_ff <= 1'b1;
        if (poll_ff && !poll_hit && tmo_cnt_ff == '0) begin
          prev_fin_ff <= 1'b1;
          tmo_ff <= 1'b1;
        end
      end
      if (st_ff != S_IDLE && st_ff != S_PWR && nxt_idle) done_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins follow the state one cycle later, all from flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      data_bus_oe <= 1'b0;
      data_bus_o <= 8'h0;
      addr_bus <= '0;
    end else begin
      ce_n <= !(st_ff == S_WSET || st_ff == S_WLOW || st_ff == S_RLOW);
      oe_n <= st_ff != S_RLOW;
      we_n <= st_ff != S_WLOW;
      data_bus_oe <= st_ff == S_WSET || st_ff == S_WLOW || st_ff == S_WREC;
      if (st_ff == S_WSET) begin
        data_bus_o <= wr_data;
        addr_bus <= wr_addr;
      end else if (st_ff == S_RLOW) begin
        addr_bus <= rd_addr;
      end
    end
  end
endmodule

// ---- shared/sfp_pkg.sv ----
// constants, register map, timing and command tables of the sector flash host controller
package sfp_pkg;
  localparam int CLK_MHZ = 125;
  localparam int FL_AW = 19;
  localparam int FL_DW = 8;
  localparam int BUF_DEPTH = 256;
  localparam int BUF_AW = 8;
  localparam int BUS_AW = 11;
  localparam int CNT_W = 22;
  // register byte offsets on the avalon slave
  localparam logic [10:0] REG_CTRL = 11'h000;
  localparam logic [10:0] REG_ADDR = 11'h004;
  localparam logic [10:0] REG_STAT = 11'h008;
  localparam logic [10:0] REG_RDAT = 11'h00c;
  localparam int BUF_SEL_BIT = 10;
  // status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_TMO = 2;
  localparam int ST_READY = 3;
  // operation codes written into ctrl[2:0]
  localparam logic [2:0] OP_READ = 3'h1;
  localparam logic [2:0] OP_PROG = 3'h2;
  localparam logic [2:0] OP_LOCK = 3'h3;
  localparam logic [2:0] OP_ERASE = 3'h4;
  localparam logic [2:0] OP_ID_ENTER = 3'h5;
  localparam logic [2:0] OP_ID_EXIT = 3'h6;
  // times as printed or chosen, then cycle counts
  localparam int T_ACC_NS = 200;
  localparam int T_WP_NS = 100;
  localparam int T_REC_NS = 50;
  localparam int T_GAP_US = 150;
  localparam int T_PWR_MS = 10;
  localparam int T_PROG_MS = 20;
  localparam int SETUP_CYC = 2;
  localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int REC_CYC = (T_REC_NS * CLK_MHZ + 999) / 1000;
  localparam int GAP_CYC = T_GAP_US * CLK_MHZ;
  localparam int PWR_CYC = T_PWR_MS * CLK_MHZ * 1000;
  localparam int PROG_CYC = T_PROG_MS * CLK_MHZ * 1000;
  // command table: {address, data}; values are arbitrary stand-ins
  localparam int SEQ_N = 21;
  localparam logic [4:0] SEQ_UNLK = 5'h00;
  localparam logic [4:0] SEQ_LOCK = 5'h03;
  localparam logic [4:0] SEQ_ERASE = 5'h09;
  localparam logic [4:0] SEQ_IDIN = 5'h0f;
  localparam logic [4:0] SEQ_IDOUT = 5'h12;
  localparam logic [4:0] SEQ_END = 5'h15;
  localparam logic [7:0] LOCK_DATA = 8'h40;
  localparam logic [26:0] SEQ_TBL [0:SEQ_N-1] = '{
    {19'h00aaa, 8'h5a}, {19'h00555, 8'ha5}, {19'h00aaa, 8'h3c},
    {19'h00aaa, 8'h5a}, {19'h00555, 8'ha5}, {19'h00aaa, 8'hc3},
    {19'h00aaa, 8'h5a}, {19'h00555, 8'ha5}, {19'h00aaa, 8'h96},
    {19'h00aaa, 8'h5a}, {19'h00555, 8'ha5}, {19'h00aaa, 8'h69},
    {19'h00aaa, 8'h5a}, {19'h00555, 8'ha5}, {19'h00aaa, 8'h0f},
    {19'h00aaa, 8'h5a}, {19'h00555, 8'ha5}, {19'h00aaa, 8'he1},
    {19'h00aaa, 8'h5a}, {19'h00555, 8'ha5}, {19'h00aaa, 8'h1e}
  };
  typedef enum logic [2:0] {S_PWR, S_IDLE, S_WSET, S_WLOW, S_WREC, S_RLOW, S_RREC} sfp_state_t;
endpackage

// ---- shared/sfp_buf_if.sv ----
// sector buffer port between controller and its byte memory
`timescale 1ns/10ps
interface sfp_buf_if #(parameter int DW = 8, parameter int AW = 8);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ---- verilog/sfp_sect_buf.sv ----
// sector staging memory with registered read data
`timescale 1ns/10ps
module sfp_sect_buf #(
  parameter int DW = 8,
  parameter int AW = 8
) (
  input wire logic clock,
  sfp_buf_if.mem bus
);
  logic [DW-1:0] mem_q [0:(1<<AW)-1];
  logic [DW-1:0] rdata_ff;

  always_ff @(posedge clock) begin
    if (bus.we) begin
      mem_q[bus.waddr] <= bus.wdata;
    end
    rdata_ff <= mem_q[bus.raddr];
  end

  assign bus.rdata = rdata_ff;
endmodule

// ---- bench/sfp_host_properties.sv ----
// concurrent checks on the flash pins and avalon handshake of the sector flash host
`timescale 1ns/10ps
module sfp_host_properties
  import sfp_pkg::*;
#(
  parameter int PWR_WAIT = 20
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [sfp_pkg::FL_AW-1:0] addr_bus,
  input wire logic [sfp_pkg::FL_DW-1:0] data_bus_o,
  input wire logic data_bus_oe,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic [31:0] up_ff;
  // counts from the raw release, so it runs ahead of the design's own wait
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) up_ff <= '0;
    else if (up_ff != 32'hffffffff) up_ff <= up_ff + 32'h1;
  end
  ////////////////////////////////////////////////////////////////
  sequence s_wlow;
    (!we_n) [*8] ##1 (!we_n) [*5];
  endsequence
  sequence s_acc;
    (!oe_n) [*8] ##1 (!oe_n) [*8] ##1 (!oe_n) [*8] ##1 (!oe_n) [*2];
  endsequence
  a_write_ctl: assert property (!we_n |-> !ce_n && oe_n && data_bus_oe)
    else $error("write strobe without select or with output enable");
  a_read_ctl: assert property (!oe_n |-> !ce_n && we_n && !data_bus_oe)
    else $error("read strobe while driving data");
  a_write_hold: assert property (!we_n |-> $stable(addr_bus) && $stable(data_bus_o))
    else $error("address or data moved during write pulse");
  a_we_width: assert property ($fell(we_n) |-> s_wlow ##1 we_n)
    else $error("write pulse length wrong");
  a_rec_gap: assert property ($rose(we_n) |-> we_n [*7])
    else $error("write recovery too short");
  a_read_len: assert property ($fell(oe_n) |-> s_acc ##1 oe_n)
    else $error("read access length wrong");
  a_pwr_delay: assert property (!ce_n |-> up_ff >= 32'(PWR_WAIT))
    else $error("flash selected during power-on wait");
  a_wait_one: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not in second cycle");
endmodule

// ---- bench/sfp_flash_model.sv ----
// behavioural parallel sector flash answering the host controller's pins
`timescale 1ns/10ps
module sfp_flash_model
  import sfp_pkg::*;
#(
  parameter int GAP = sfp_pkg::GAP_CYC,
  parameter int BUSY = 300,
  parameter logic [7:0] MAKER = 8'h3a, // arbitrary value
  parameter logic [7:0] PART = 8'h5c // arbitrary value
) (
  input wire logic clock,
  input wire logic [sfp_pkg::FL_AW-1:0] addr_bus,
  input wire logic [sfp_pkg::FL_DW-1:0] data_bus_o,
  input wire logic data_bus_oe,
  output logic [sfp_pkg::FL_DW-1:0] data_bus_i,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n
);
  logic [7:0] mem [int];
  logic [7:0] pg [int];
  logic [26:0] hist [0:6];
  logic [18:0] la;
  logic [10:0] sect;
  logic [7:0] last = 8'h00;
  logic [7:0] q = 8'h00;
  logic loading = 0, busy = 0, tog = 0, id = 0, ok = 0;
  logic lk_lo = 0, lk_hi = 0;
  int gap_cnt, busy_cnt;
  realtime t0 = 0;
  wire wr = !ce_n && !we_n && oe_n;
  wire rd = !ce_n && !oe_n && we_n;
  // a released line shows the inverse of its last value, never a lucky guess
  assign data_bus_i = data_bus_oe ? data_bus_o : (rd && ok) ? q : ~q;
  ////////////////////////////////////////////////////////////////
  function automatic bit hit(int b, int n, int o);
    hit = 1;
    for (int k = 0; k < n; k++) if (hist[7-o-n+k] !== SEQ_TBL[b+k]) hit = 0;
  endfunction
  always @(posedge wr) begin
    t0 = $realtime;
    la = addr_bus;
  end
  // data is taken as the strobes rise again
  always @(negedge wr) begin
    if ($realtime - t0 >= 15.0 && !busy) begin
      for (int k = 0; k < 6; k++) hist[k] = hist[k + 1];
      hist[6] = {la, data_bus_o};
      if (loading) begin
        pg[la[7:0]] = data_bus_o;
        sect = la[18:8];
        last = data_bus_o;
        gap_cnt = 0;
      end else if (hit(SEQ_UNLK, 3, 0)) begin
        loading = 1;
        pg.delete();
        gap_cnt = 0;
      end else if (hit(SEQ_LOCK, 6, 1) && data_bus_o == LOCK_DATA) begin
        lk_lo = lk_lo | (la < 19'h04000);
        lk_hi = lk_hi | (la >= 19'h7c000);
      end else if (hit(SEQ_ERASE, 6, 0) && !lk_lo && !lk_hi) begin
        mem.delete();
        busy = 1;
        busy_cnt = 0;
      end else if (hit(SEQ_IDIN, 3, 0)) id = 1;
      else if (hit(SEQ_IDOUT, 3, 0)) id = 0;
    end
  end
  always @(posedge clock) begin
    if (loading && ++gap_cnt >= GAP) begin
      loading = 0;
      busy = 1;
      busy_cnt = 0;
      if (!(sect < 11'h040 && lk_lo) && !(sect >= 11'h7c0 && lk_hi))
        for (int i = 0; i < 256; i++) mem[{sect, i[7:0]}] = pg.exists(i) ? pg[i] : 8'hxx;
    end else if (busy && ++busy_cnt >= BUSY) busy = 0;
  end
  always @(posedge rd) begin
    ok = 0;
    // look up late so an address launched with the strobes has settled
    #(T_ACC_NS - 20);
    if (busy || loading) begin
      tog = ~tog;
      q = {~last[7], tog, last[5:0]};
    end else if (id) q = addr_bus == 19'h2 ? {7'h7f, lk_lo} : addr_bus == 19'h7fff2 ? {7'h7f, lk_hi} :
      addr_bus[0] ? PART : MAKER;
    else q = mem.exists(addr_bus) ? mem[addr_bus] : 8'hff;
    ok = 1;
  end
endmodule

// ---- bench/tb.sv ----
// self-checking bench for the sector flash host driven through avalon tasks
`timescale 1ns/10ps
module tb;
  import sfp_pkg::*;
  logic clock = 0;
  logic nrst = 0;
  logic [10:0] avs_address = '0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, data_bus_oe, ce_n, oe_n, we_n;
  logic [18:0] addr_bus;
  logic [7:0] data_bus_o, data_bus_i;
  int n_mismatch = 0;
  int tests_run = 0;
  always #4 clock = ~clock;
  sfp_host #(.PWR_WAIT(20), .POLL_MAX(5000)) dut (.clock(clock), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .addr_bus(addr_bus),
    .data_bus_o(data_bus_o), .data_bus_oe(data_bus_oe), .data_bus_i(data_bus_i), .ce_n(ce_n),
    .oe_n(oe_n), .we_n(we_n));
  // short load gap keeps the run brief; the host still loads far faster
  sfp_flash_model #(.GAP(2000)) flash (.clock(clock), .addr_bus(addr_bus), .data_bus_o(data_bus_o),
    .data_bus_oe(data_bus_oe), .data_bus_i(data_bus_i), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n));
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic av(input logic wr, input logic [10:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    @(posedge clock);
  endtask
  task automatic op(input logic [2:0] c, input logic [18:0] a);
    av(1, REG_ADDR, {13'h0, a});
    av(1, REG_CTRL, {29'h0, c});
    rd = 1;
    while (rd[ST_BUSY] !== 1'b0) av(0, REG_STAT, 0);
    chk(rd & 32'hf, 32'ha);
  endtask
  task automatic rdf(input logic [18:0] a, input logic [7:0] e);
    op(OP_READ, a);
    av(0, REG_RDAT, 0);
    chk(rd, {24'h0, e});
  endtask
  task automatic prog(input logic [10:0] s, input logic [7:0] k);
    for (int i = 0; i < 256; i++) av(1, 11'h400 + 11'(4 * i), {24'h0, 8'(i) ^ k});
    op(OP_PROG, {s, 8'h00});
  endtask
  initial begin
    repeat (8) @(posedge clock);
    nrst <= 1;
    repeat (3) @(posedge clock);
    av(1, REG_CTRL, {29'h0, OP_PROG});
    rd = 0;
    while (rd[ST_READY] !== 1'b1) av(0, REG_STAT, 0);
    chk(rd & 32'hf, 32'h8);
    av(0, 11'h010, 0);
    chk(rd, 0);
    av(1, REG_CTRL, 0);
    av(0, REG_STAT, 0);
    chk(rd & 32'hf, 32'h8);
    // only enabled lanes land; a command without lane 0 is dropped
    avs_byteenable <= 4'h2;
    av(1, REG_ADDR, 32'h00012345);
    avs_byteenable <= 4'h0;
    av(1, REG_CTRL, {29'h0, OP_READ});
    avs_byteenable <= 4'hf;
    av(0, REG_ADDR, 0);
    chk(rd, 32'h00002300);
    av(0, REG_STAT, 0);
    chk(rd & 32'hf, 32'h8);
    rdf(19'h00500, 8'hff);
    prog(11'h005, 8'h5a);
    rdf(19'h00500, 8'h5a);
    rdf(19'h005ff, 8'ha5);
    prog(11'h005, 8'h33);
    rdf(19'h00580, 8'hb3);
    op(OP_ERASE, 0);
    rdf(19'h005ff, 8'hff);
    prog(11'h005, 8'h0f);
    op(OP_ID_ENTER, 0);
    rdf(19'h00002, 8'hfe);
    rdf(19'h7fff2, 8'hfe);
    op(OP_ID_EXIT, 0);
    op(OP_LOCK, 19'h00010);
    op(OP_ID_ENTER, 0);
    rdf(19'h00002, 8'hff);
    rdf(19'h7fff2, 8'hfe);
    op(OP_ID_EXIT, 0);
    prog(11'h001, 8'h00);
    rdf(19'h00101, 8'hff);
    op(OP_ERASE, 0);
    rdf(19'h00510, 8'h1f);
    give_verdict;
  end
  initial begin
    repeat (80000) @(posedge clock);
    n_mismatch++;
    give_verdict;
  end
endmodule
bind sfp_host sfp_host_properties #(.PWR_WAIT(PWR_WAIT)) u_props (.clock(clock), .nrst(nrst),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .addr_bus(addr_bus),
  .data_bus_o(data_bus_o), .data_bus_oe(data_bus_oe), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n));
